// [core/spid_pkg.sv]
// constants and types for the stack position and identity decoder
package spid_pkg;

    localparam int          SPID_LINES       = 4;
    localparam int          SPID_IDW         = 2;
    localparam logic [3:0]  SPID_LINES_IDLE  = 4'hF;
    localparam logic [1:0]  SPID_PROC_ID     = 2'h0;
    localparam logic [3:0]  SPID_REGION_BASE = 4'hC;
    localparam int          SPID_NIB_MSB     = 31;
    localparam int          SPID_NIB_LSB     = 28;

    typedef struct packed {
        logic [3:0] pos_meta;
        logic [3:0] pos_sync;
        logic [3:0] irq_meta;
        logic [3:0] irq_sync;
        logic [3:0] fiq_meta;
        logic [3:0] fiq_sync;
        logic [1:0] id;
        logic       valid;
        logic       irq_n;
        logic       fiq_n;
        logic       sel;
        logic [3:0] proc_pres_n;
        logic [3:0] logic_pres_n;
    } spid_state_t;

    localparam spid_state_t SPID_STATE_RST = '{
        pos_meta:     SPID_LINES_IDLE,
        pos_sync:     SPID_LINES_IDLE,
        irq_meta:     SPID_LINES_IDLE,
        irq_sync:     SPID_LINES_IDLE,
        fiq_meta:     SPID_LINES_IDLE,
        fiq_sync:     SPID_LINES_IDLE,
        id:           SPID_PROC_ID,
        valid:        1'b0,
        irq_n:        1'b1,
        fiq_n:        1'b1,
        sel:          1'b0,
        proc_pres_n:  SPID_LINES_IDLE,
        logic_pres_n: SPID_LINES_IDLE
    };

endpackage

// [core/spid_onehot_decode.sv]
// active-low line group to index decoder, lowest low line wins
`timescale 1ns/1ps
module spid_onehot_decode
    import spid_pkg::*;
(
    // line group
    input  wire logic [3:0] lines_n_i,
    // result
    output logic [1:0]      index_o,
    output logic            valid_o
);

    always_comb
    begin
        index_o = 2'h0;
        valid_o = 1'b0;
        for (int i = SPID_LINES - 1; i >= 0; i--)
        begin
            if (!lines_n_i[i])
            begin
                index_o = 2'(i);
                valid_o = 1'b1;
            end
        end
    end

endmodule // spid_onehot_decode

// [core/spid_stack_decode.sv]
// stack position, identity, interrupt pick, presence and region decode
// Functional notes
// - take irq and fast irq from the line pair indexed by identity
// - logic module identity comes from position; region and interrupts follow it
// - processor module always id 0; logic modules id 1 to 3
// - presence reported on separate four-line groups per module kind
// - position lines give both stack place and own address range
// - one line low per group unless extra ranges are claimed
// - logic modules decode their own region; processor does not
// - bus request and grant never pick the master
`timescale 1ns/1ps
module spid_stack_decode
    import spid_pkg::*;
#(
    parameter bit         IS_LOGIC_MODULE = 1'b1,
    parameter logic [3:0] EXTRA_CLAIM     = 4'h0
)
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // stack pins
    input  wire logic [3:0] stack_position_n_i,
    input  wire logic [3:0] normal_irq_line_n_i,
    input  wire logic [3:0] fast_irq_line_n_i,
    // bus address from the local bus clock domain
    input  wire logic [31:0] bus_addr_i,
    input  wire logic        bus_addr_valid_i,
    // presence groups, open drain
    output logic [3:0]      processor_module_present_n_o,
    output logic [3:0]      processor_module_present_n_oe_o,
    output logic [3:0]      logic_module_present_n_o,
    output logic [3:0]      logic_module_present_n_oe_o,
    // unused arbitration pin, open drain
    output logic            bus_request_n_o,
    output logic            bus_request_n_oe_o,
    // decoded results
    output logic [1:0]      module_id_o,
    output logic            position_valid_o,
    output logic            irq_n_o,
    output logic            fiq_n_o,
    output logic            select_o
);

    ////////////////////////////////////////////////////////////////////
    spid_state_t state_reg;
    spid_state_t state_next;
    logic [1:0]  pos_index;
    logic        pos_found;
    logic [3:0]  own_nib;

    spid_onehot_decode u_pos_decode (
        .lines_n_i (state_reg.pos_sync),
        .index_o   (pos_index),
        .valid_o   (pos_found)
    );

    assign own_nib = SPID_REGION_BASE + {2'h0, state_reg.id};

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next          = state_reg;
        state_next.pos_meta = stack_position_n_i;
        state_next.pos_sync = state_reg.pos_meta;
        state_next.irq_meta = normal_irq_line_n_i;
        state_next.irq_sync = state_reg.irq_meta;
        state_next.fiq_meta = fast_irq_line_n_i;
        state_next.fiq_sync = state_reg.fiq_meta;
        // identity from position on logic modules; processor module fixed at id 0
        if (IS_LOGIC_MODULE)
        begin
            state_next.id    = pos_index;
            state_next.valid = pos_found
                               && (pos_index != SPID_PROC_ID);
        end
        else
        begin
            state_next.id    = SPID_PROC_ID;
            state_next.valid = pos_found;
        end
        // interrupt pair indexed by identity
        state_next.irq_n = state_reg.valid ?
                           state_reg.irq_sync[state_reg.id] : 1'b1;
        state_next.fiq_n = state_reg.valid ?
                           state_reg.fiq_sync[state_reg.id] : 1'b1;
        // presence: one low line, plus any extra claims
        state_next.proc_pres_n  = SPID_LINES_IDLE;
        state_next.logic_pres_n = SPID_LINES_IDLE;
        if (state_reg.valid)
        begin
            if (IS_LOGIC_MODULE)
            begin
                state_next.logic_pres_n = ~EXTRA_CLAIM;
                state_next.logic_pres_n[state_reg.id] = 1'b0;
            end
            else
            begin
                state_next.proc_pres_n = ~EXTRA_CLAIM;
                state_next.proc_pres_n[state_reg.id] = 1'b0;
            end
        end
        // own region decode, logic modules only
        state_next.sel = IS_LOGIC_MODULE && state_reg.valid
                         && bus_addr_valid_i
                         && (bus_addr_i[SPID_NIB_MSB:SPID_NIB_LSB]
                             == own_nib);
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state_reg <= SPID_STATE_RST;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////
    assign processor_module_present_n_o    = 4'h0;
    assign processor_module_present_n_oe_o = ~state_reg.proc_pres_n;
    assign logic_module_present_n_o        = 4'h0;
    assign logic_module_present_n_oe_o     = ~state_reg.logic_pres_n;
    // single master: request never driven
    assign bus_request_n_o    = 1'b1;
    assign bus_request_n_oe_o = 1'b0;
    assign module_id_o        = state_reg.id;
    assign position_valid_o   = state_reg.valid;
    assign irq_n_o            = state_reg.irq_n;
    assign fiq_n_o            = state_reg.fiq_n;
    assign select_o           = state_reg.sel;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_pos_settled;
        $stable(state_reg.pos_sync) [*3];
    endsequence

    // address phase aimed at the own region
    sequence s_own_hit;
        bus_addr_valid_i && state_reg.valid
            && bus_addr_i[SPID_NIB_MSB:SPID_NIB_LSB] == own_nib;
    endsequence

    a_irq_pick_index: assert property (
        state_reg.valid
        |=> irq_n_o == $past(state_reg.irq_sync[state_reg.id])
            && fiq_n_o == $past(state_reg.fiq_sync[state_reg.id]))
        else $error("irq pair not taken from own index");

    a_irq_idle_high: assert property (
        !state_reg.valid |=> irq_n_o && fiq_n_o)
        else $error("irq driven without valid position");

    a_id_from_pos: assert property (
        s_pos_settled ##0 pos_found && IS_LOGIC_MODULE
        |-> module_id_o == pos_index)
        else $error("identity does not follow position");

    a_proc_id_zero: assert property (
        !IS_LOGIC_MODULE |-> module_id_o == SPID_PROC_ID)
        else $error("processor module id not zero");

    a_logic_id_range: assert property (
        IS_LOGIC_MODULE && position_valid_o |-> module_id_o != SPID_PROC_ID)
        else $error("logic module took id zero");

    a_group_split: assert property (
        (IS_LOGIC_MODULE ? processor_module_present_n_oe_o
                         : logic_module_present_n_oe_o) == 4'h0)
        else $error("presence on wrong group");

    a_pos_track: assert property (
        s_pos_settled ##0 !pos_found |=> !position_valid_o)
        else $error("valid without any position line low");

    a_one_hot_pres: assert property (
        position_valid_o && EXTRA_CLAIM == 4'h0
        |=> $countones(processor_module_present_n_oe_o
                       | logic_module_present_n_oe_o) == 1)
        else $error("presence group not one-hot");

    a_proc_no_sel: assert property (
        !IS_LOGIC_MODULE |-> !select_o)
        else $error("processor module decoded a region");

    a_no_bus_req: assert property (
        !bus_request_n_oe_o)
        else $error("bus request driven on single-master bus");

    a_sel_region: assert property (
        select_o |-> $past(bus_addr_valid_i)
                     && $past(bus_addr_i[SPID_NIB_MSB:SPID_NIB_LSB])
                        == $past(own_nib))
        else $error("select outside own region");

    a_sel_hit: assert property (
        s_own_hit ##0 IS_LOGIC_MODULE |=> select_o)
        else $error("own region address not selected");

    a_pres_idle: assert property (
        !position_valid_o
        |=> (processor_module_present_n_oe_o
             | logic_module_present_n_oe_o) == 4'h0)
        else $error("presence driven without valid position");

    a_logic_own_line: assert property (
        IS_LOGIC_MODULE && position_valid_o
        |=> logic_module_present_n_oe_o[$past(module_id_o)])
        else $error("own logic presence line not pulled");

    a_proc_own_line: assert property (
        !IS_LOGIC_MODULE && position_valid_o
        |=> processor_module_present_n_oe_o[$past(module_id_o)])
        else $error("own processor presence line not pulled");

    a_pos_to_valid: assert property (
        pos_found && !(IS_LOGIC_MODULE && pos_index == SPID_PROC_ID)
        |=> position_valid_o)
        else $error("usable position not reported valid");

    a_id_hold: assert property (
        position_valid_o && $stable(state_reg.pos_sync)
        |=> $stable(module_id_o))
        else $error("identity moved while position held");

endmodule // spid_stack_decode

// [sim/spid_baseboard_model.sv]
// baseboard model driving the rotated position and interrupt lines
`timescale 1ns/1ps
module spid_baseboard_model
    import spid_pkg::*;
(
    // control from the bench
    input  wire logic [1:0] pos_idx_i,
    input  wire logic       pos_en_i,
    input  wire logic [1:0] irq_idx_i,
    input  wire logic       irq_en_i,
    input  wire logic       fiq_en_i,
    // stack lines, pulled up when released
    output logic [3:0]      stack_position_n_o,
    output logic [3:0]      normal_irq_line_n_o,
    output logic [3:0]      fast_irq_line_n_o
);
    // one low line at the module's place, pull-ups elsewhere
    assign stack_position_n_o = pos_en_i ? ~(4'h1 << pos_idx_i)
                                         : SPID_LINES_IDLE;
    // one interrupt pair per stack index
    assign normal_irq_line_n_o = irq_en_i ? ~(4'h1 << irq_idx_i)
                                          : SPID_LINES_IDLE;
    assign fast_irq_line_n_o   = fiq_en_i ? ~(4'h1 << irq_idx_i)
                                          : SPID_LINES_IDLE;
    // single master: no grant line is offered at all
endmodule // spid_baseboard_model

// [sim/tb_top.sv]
// self-checking testbench for the stack decoder as a logic module
`timescale 1ns/1ps
module tb_top;
    import spid_pkg::*;
    logic        clk;
    logic        nrst_n;
    logic [1:0]  pos_idx, irq_idx;
    logic        pos_en, irq_en, fiq_en, addr_v;
    logic [31:0] addr;
    logic [3:0]  pos_n, irq_l, fiq_l, pp_d, pp_oe, lp_d, lp_oe;
    logic [1:0]  id;
    logic        br_d, br_oe, vld, irq_n, fiq_n, sel;
    int          bad_count;
    int          total_checks;

    spid_baseboard_model spid_baseboard_model_inst (
        .pos_idx_i(pos_idx), .pos_en_i(pos_en), .irq_idx_i(irq_idx),
        .irq_en_i(irq_en), .fiq_en_i(fiq_en), .stack_position_n_o(pos_n),
        .normal_irq_line_n_o(irq_l), .fast_irq_line_n_o(fiq_l));
    spid_stack_decode spid_stack_decode_inst (
        .clk_i(clk), .nrst_i(nrst_n), .stack_position_n_i(pos_n),
        .normal_irq_line_n_i(irq_l), .fast_irq_line_n_i(fiq_l),
        .bus_addr_i(addr), .bus_addr_valid_i(addr_v),
        .processor_module_present_n_o(pp_d),
        .processor_module_present_n_oe_o(pp_oe),
        .logic_module_present_n_o(lp_d), .logic_module_present_n_oe_o(lp_oe),
        .bus_request_n_o(br_d), .bus_request_n_oe_o(br_oe),
        .module_id_o(id), .position_valid_o(vld), .irq_n_o(irq_n),
        .fiq_n_o(fiq_n), .select_o(sel));

    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [3:0] e,
                       input logic [3:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // place p: identity, presence line and interrupt pair
    task automatic position_case(input logic [1:0] p);
        pos_idx = p;
        pos_en = 1'b1;
        irq_idx = p;
        irq_en = 1'b1;
        fiq_en = 1'b0;
        step(5);
        chk("id", {2'h0, p}, {2'h0, id});
        chk("valid", 4'h1, {3'h0, vld});
        chk("logic_oe", 4'h1 << p, lp_oe);
        chk("proc_oe", 4'h0, pp_oe);
        chk("pres_data", 4'h0, lp_d);
        chk("proc_data", 4'h0, pp_d);
        chk("irq", 4'h0, {3'h0, irq_n});
        chk("fiq", 4'h1, {3'h0, fiq_n});
        // both pairs moved to a neighbour's index
        irq_idx = p + 2'h1;
        fiq_en = 1'b1;
        step(4);
        chk("irq_other", 4'h1, {3'h0, irq_n});
        chk("fiq_other", 4'h1, {3'h0, fiq_n});
        irq_idx = p;
        step(4);
        chk("irq_own", 4'h0, {3'h0, irq_n});
        chk("fiq_own", 4'h0, {3'h0, fiq_n});
        irq_en = 1'b0;
        fiq_en = 1'b0;
    endtask
    // region decode: own nibble hits back to back, others miss
    task automatic select_case(input logic [1:0] p);
        addr = {SPID_REGION_BASE + {2'h0, p}, 28'h0ABCDEF};
        addr_v = 1'b1;
        step(1);
        chk("sel_hit", 4'h1, {3'h0, sel});
        addr = {SPID_REGION_BASE + {2'h0, p}, 28'h0};
        step(1);
        chk("sel_back", 4'h1, {3'h0, sel});
        addr = {SPID_REGION_BASE, 28'h0};
        step(1);
        chk("sel_proc", 4'h0, {3'h0, sel});
        addr = {SPID_REGION_BASE + {2'h0, p ^ 2'h3}, 28'h0};
        step(1);
        chk("sel_other", 4'h0, {3'h0, sel});
        addr = {SPID_REGION_BASE + {2'h0, p}, 28'h0};
        addr_v = 1'b0;
        step(1);
        chk("sel_idle", 4'h0, {3'h0, sel});
    endtask
    // mid-run reset clears outputs; no low position line is refused
    task automatic reset_case;
        pos_idx = 2'h2;
        irq_idx = 2'h2;
        irq_en = 1'b1;
        step(5);
        chk("pre_rst_valid", 4'h1, {3'h0, vld});
        nrst_n = 1'b0;
        #1;
        chk("rst_valid", 4'h0, {3'h0, vld});
        chk("rst_oe", 4'h0, lp_oe | pp_oe);
        chk("rst_irq", 4'h1, {3'h0, irq_n});
        step(2);
        nrst_n = 1'b1;
        step(3);
        chk("rel_id", 4'h2, {2'h0, id});
        chk("rel_oe", 4'h0, lp_oe);
        step(1);
        chk("rel_pres", 4'h4, lp_oe);
        chk("rel_irq", 4'h0, {3'h0, irq_n});
        pos_en = 1'b0;
        irq_en = 1'b0;
        step(4);
        chk("none_valid", 4'h0, {3'h0, vld});
        chk("none_oe", 4'h0, lp_oe | pp_oe);
    endtask
    // logic module at place 0 is refused
    task automatic bottom_case;
        pos_idx = 2'h0;
        irq_idx = 2'h0;
        irq_en = 1'b1;
        addr_v = 1'b1;
        addr = {SPID_REGION_BASE, 28'h0};
        step(6);
        chk("valid0", 4'h0, {3'h0, vld});
        chk("oe0", 4'h0, lp_oe | pp_oe);
        chk("irq0", 4'h1, {3'h0, irq_n});
        chk("sel0", 4'h0, {3'h0, sel});
        chk("busreq", 4'h0, {3'h0, br_oe});
        chk("busreq_d", 4'h1, {3'h0, br_d});
        addr_v = 1'b0;
        irq_en = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #(40 * 2000);
        bad_count++;
        test_done();
    end
    initial
    begin
        bad_count = 0;
        total_checks = 0;
        nrst_n = 1'b0;
        pos_idx = 2'h0;
        pos_en = 1'b0;
        irq_idx = 2'h0;
        irq_en = 1'b0;
        fiq_en = 1'b0;
        addr = 32'h0;
        addr_v = 1'b0;
        step(4);
        nrst_n = 1'b1;
        for (int i = 1; i < 4; i++)
        begin
            position_case(i[1:0]);
            select_case(i[1:0]);
        end
        bottom_case();
        reset_case();
        test_done();
    end
endmodule // tb_top
